//--- rtl/reset_init_pkg.sv
// Package with the register map, reset values and timing of the reset state initializer.
package reset_init_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------

   localparam real CLK_MHZ = 125.0;
   localparam real STAB_TIME_MS = 31.3; // Oscillation stabilization interval.
   localparam int STAB_CYCLES_DEF = int'($ceil(STAB_TIME_MS * CLK_MHZ * 1000.0));

   // ----------------------------------------------------------------
   // Word indices on the bus (byte address is four times the index)
   // ----------------------------------------------------------------

   localparam logic [11:0] PORT_LATCH_BASE = 12'hff0; // Port 0..9 latches, bank 15.
   localparam logic [11:0] DIR_BASE = 12'hfe6; // Direction flag nibbles, bank 15.
   localparam logic [11:0] CTRL_BASE = 12'hf80; // Peripheral control registers.
   localparam logic [11:0] IDX_BASIC_COUNT_REG = 12'hf9d;
   localparam logic [11:0] IDX_SERIAL_SHIFT_BUFFER = 12'hf9e;
   localparam logic [11:0] IDX_STATUS = 12'hf9f;
   localparam logic [11:0] SCRATCH_LO = 12'h0f8; // Never retained across reset.
   localparam logic [11:0] SCRATCH_HI = 12'h0fd;
   localparam int SCRATCH_WORDS = 6;
   localparam logic [11:0] DISP_BASE = 12'h1e0; // Display data memory.
   localparam int DISP_DEPTH_DEF = 56;

   // ----------------------------------------------------------------
   // Port layout
   // ----------------------------------------------------------------

   localparam int NUM_PORTS = 10;
   localparam int PIN_COUNT = 40;
   localparam logic [39:0] IO_MASK = 40'hfffffff70f; // 35 configurable pins.
   localparam logic [39:0] PIN_MASK = 40'hfffffff7ff; // 39 pins in all.
   localparam logic [3:0] DIR_SLOT [NUM_PORTS] = '{4'h0, 4'h3, 4'h1, 4'h2, 4'h4,
                                                   4'h5, 4'h6, 4'h7, 4'h8, 4'h9};

   // ----------------------------------------------------------------
   // Control register offsets from CTRL_BASE
   // ----------------------------------------------------------------

   localparam int OFS_POWER_CTRL_REG = 0;
   localparam int OFS_CLK_OUT_MODE_REG = 1;
   localparam int OFS_SYS_CLK_MODE_REG = 2;
   localparam int OFS_INT_REQUEST_FLAG = 3;
   localparam int OFS_INT_ENABLE_FLAG = 4;
   localparam int OFS_INT_PRIORITY_FLAG = 5;
   localparam int OFS_INT_MASTER_ENABLE = 6;
   localparam int OFS_EXT_INT0_MODE_REG = 7;
   localparam int OFS_EXT_INT1_MODE_REG = 8;
   localparam int OFS_EXT_INT2_MODE_REG = 9;
   localparam int OFS_KEY_INT_MODE_REG = 10;
   localparam int OFS_PULLUP_SELECT_REG1 = 11;
   localparam int OFS_PULLUP_SELECT_REG2 = 12;
   localparam int OFS_OPEN_DRAIN_SELECT_REG = 13;
   localparam int OFS_BASIC_TIMER_MODE = 14;
   localparam int OFS_WATCHDOG_MODE_REG = 15;
   localparam int OFS_WATCHDOG_CLEAR_FLAG = 16;
   localparam int OFS_TIMER0_COUNT_REG = 17;
   localparam int OFS_TIMER1_COUNT_REG = 18;
   localparam int OFS_TIMER0_REFERENCE_REG = 19;
   localparam int OFS_TIMER1_REFERENCE_REG = 20;
   localparam int OFS_TIMER0_MODE_REG = 21;
   localparam int OFS_TIMER1_MODE_REG = 22;
   localparam int OFS_TIMER_OUTPUT_ENABLE = 23;
   localparam int OFS_WATCH_TIMER_MODE = 24;
   localparam int OFS_DISPLAY_CONTRAST_REG = 25;
   localparam int OFS_DISPLAY_MODE_REG = 26;
   localparam int OFS_DISPLAY_CONTROL_REG = 27;
   localparam int OFS_SERIAL_MODE_REG = 28;
   localparam int NUM_CTRL = 29;

   // Reset values and writable bits, one entry per offset above.
   localparam logic [15:0] CTRL_RESET [NUM_CTRL] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h00a5,
      16'h0000, 16'h0000, 16'h0000, 16'h00ff, 16'hffff, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [15:0] CTRL_MASK [NUM_CTRL] = '{
      16'h000f, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h0007, 16'h0001, 16'h00ff,
      16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h0003, 16'h0fff, 16'h000f, 16'h00ff,
      16'h0001, 16'h00ff, 16'hffff, 16'h00ff, 16'hffff, 16'h00ff, 16'h00ff, 16'h0003,
      16'h00ff, 16'h000f, 16'h00ff, 16'h000f, 16'h00ff};

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------

   localparam int DISP_ON_BIT = 0; // Display control: output buffers on.
   localparam int STAT_HOLD_BIT = 0; // Status: processor held idle.
   localparam int STAT_RETAINED_BIT = 1; // Status: memories were retained.

endpackage

//--- rtl/pin_synchronizer.sv
// Two-flop synchronizer for the port pin inputs.
`timescale 1ns/10ps
module pin_synchronizer #(
   parameter int WIDTH = 40 // Number of pins.
) (
   input wire logic sys_clk, // System clock.
   input wire logic rst_n, // Synchronized reset, active low.
   input wire logic [WIDTH-1:0] async_in, // Raw pin levels.
   output logic [WIDTH-1:0] sync_out // Levels safe to use.
);

   logic [WIDTH-1:0] meta;

   // The first stage feeds only the second, so a metastable level never fans out.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule

//--- rtl/reset_state_initializer.sv
// Reset state initializer: control registers, port pins and post-reset sequencing.
`timescale 1ns/10ps
// Function
// R01 - Reset clears power and clock mode registers.
// R02 - Reset clears all interrupt flags and enables.
// R03 - Reset clears external and key interrupt modes.
// R04 - Scratch words 0F8H-0FDH never survive reset.
// R05 - Reset disables buffers, clears latches, directions, pull-ups.
// R06 - Watchdog mode presets A5H, basic timer cleared; basic_count_reg has no reset and keeps its value.
// R07 - Timers cleared, references preset to all ones.
// R08 - Reset clears the watch timer mode.
// R09 - Reset clears display controls, buffers off.
// R10 - Display memory, serial buffer kept after power-down.
// R11 - Reset clears serial mode, interface idle.
// R12 - Reset clears open-drain selects, push-pull default.
// R13 - Ten ports: 4 input, 35 configurable pins.
// R14 - Port latches mapped into memory bank 15.
// R15 - Per-pin direction flag gates output buffer.
// R16 - Direction 0 is input, 1 is output.
// R17 - Output pins never enable their pull-up.
// R18 - Hold processor idle for stabilization interval.
// R19 - Record power-down at reset to choose retention.
module reset_state_initializer
   import reset_init_pkg::*;
#(
   parameter int STAB_CYCLES = STAB_CYCLES_DEF, // Stabilization hold in clock cycles.
   parameter int DISP_DEPTH = DISP_DEPTH_DEF // Display memory depth in nibbles.
) (
   input wire logic sys_clk, // 125 MHz system clock.
   input wire logic rst_n, // External reset, active low.
   input wire logic por_n, // Power-on reset, active low.
   input wire logic cpu_idle, // Processor is in idle mode.
   input wire logic cpu_stop, // Processor is in stop mode.
   input wire logic hsel, // AHB-Lite slave select.
   input wire logic [31:0] haddr, // AHB-Lite address.
   input wire logic [1:0] htrans, // AHB-Lite transfer type.
   input wire logic hwrite, // AHB-Lite write.
   input wire logic [2:0] hsize, // AHB-Lite size, words only.
   input wire logic [31:0] hwdata, // AHB-Lite write data.
   input wire logic hready, // AHB-Lite bus ready.
   output logic hreadyout, // AHB-Lite slave ready.
   output logic hresp, // AHB-Lite response, always OKAY.
   output logic [31:0] hrdata, // AHB-Lite read data.
   input wire logic [PIN_COUNT-1:0] pin_in, // Port pin levels.
   output logic [PIN_COUNT-1:0] pin_out, // Port output latches.
   output logic [PIN_COUNT-1:0] pin_oe, // Port output buffer enables.
   output logic [PIN_COUNT-1:0] pin_pullup, // Port pull-up enables.
   output logic disp_out_en, // Display output buffers on.
   output logic cpu_hold, // Processor held idle.
   output logic mem_retained // Memories kept across last reset.
);

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------

   if (STAB_CYCLES < 1 || DISP_DEPTH < 1 || DISP_DEPTH > 512) begin : g_bad_param
      $error("reset_state_initializer: STAB_CYCLES or DISP_DEPTH out of range");
   end

   localparam int HOLD_W = $clog2(STAB_CYCLES + 1);

   // ----------------------------------------------------------------
   // Reset synchronizers
   // ----------------------------------------------------------------

   logic [1:0] rst_pipe;
   logic [1:0] por_pipe;
   logic rst_sync_n;
   logic por_sync_n;
   wire rst_any_n = rst_n & por_n;

   // Assert at once, release two edges later so no flop sees a runt release.
   always_ff @(posedge sys_clk or negedge rst_any_n) begin
      if (!rst_any_n) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   // Power-on reset alone clears the power-down record.
   always_ff @(posedge sys_clk or negedge por_n) begin
      if (!por_n) begin
         por_pipe <= 2'b00;
      end else begin
         por_pipe <= {por_pipe[0], 1'b1};
      end
   end

   assign rst_sync_n = rst_pipe[1];
   assign por_sync_n = por_pipe[1];

   // ----------------------------------------------------------------
   // Power-down record and stabilization hold
   // ----------------------------------------------------------------

   logic pd_record;
   logic first_cycle;
   logic retained;
   logic [HOLD_W-1:0] hold_cnt;
   logic scrub;

   // The record freezes while reset is held, so it shows the mode at the moment reset came.
   always_ff @(posedge sys_clk or negedge por_sync_n) begin
      if (!por_sync_n) begin
         pd_record <= 1'b0;
      end else if (rst_sync_n) begin
         pd_record <= cpu_idle | cpu_stop; // R19
      end
   end

   // The first cycle after release decides retention from the frozen record.
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         first_cycle <= 1'b1;
         retained <= 1'b0;
      end else begin
         first_cycle <= 1'b0;
         if (first_cycle) begin
            retained <= pd_record; // R19
         end
      end
   end

   // Contents from a normal-mode reset are not guaranteed; clearing them is one legal outcome.
   assign scrub = first_cycle & ~pd_record; // R10

   // Down-counter for the oscillation stabilization interval.
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         hold_cnt <= HOLD_W'(STAB_CYCLES);
      end else if (hold_cnt != '0) begin
         hold_cnt <= hold_cnt - 1'b1; // R18
      end
   end

   assign cpu_hold = ~rst_sync_n | (hold_cnt != '0); // R18
   assign mem_retained = retained;

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------

   logic wr_pend;
   logic [11:0] wr_idx;
   logic [31:0] rd_data;
   wire addr_ok = (haddr[31:14] == 18'h0);
   wire [11:0] idx = haddr[13:2];
   wire accept = hsel & hready & htrans[1];

   // Writes take one wait state so a following read always sees the new value.
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wr_pend <= 1'b0;
         wr_idx <= 12'h000;
      end else begin
         wr_pend <= accept & hwrite;
         if (accept) begin
            wr_idx <= addr_ok ? idx : 12'h000;
         end
      end
   end

   // Read data is captured at the address phase, so reads finish with no wait state.
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         hrdata <= 32'h0;
      end else if (accept & ~hwrite) begin
         hrdata <= addr_ok ? rd_data : 32'h0;
      end
   end

   assign hreadyout = ~wr_pend;
   assign hresp = 1'b0;

   // ----------------------------------------------------------------
   // Peripheral control registers
   // ----------------------------------------------------------------

   logic [15:0] ctrl_reg [NUM_CTRL];
   logic [NUM_CTRL-1:0] ctrl_hit;

   for (genvar c = 0; c < NUM_CTRL; c++) begin : g_ctrl_hit
      assign ctrl_hit[c] = wr_pend & (wr_idx == CTRL_BASE + 12'(c));
   end

   // Every control register takes its documented reset value on any reset.
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         for (int c = 0; c < NUM_CTRL; c++) begin
            ctrl_reg[c] <= CTRL_RESET[c]; // R01 R02 R03 R06 R07 R08 R09 R11 R12
         end
      end else begin
         for (int c = 0; c < NUM_CTRL; c++) begin
            if (ctrl_hit[c]) begin
               ctrl_reg[c] <= hwdata[15:0] & CTRL_MASK[c];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Scratch words that never survive reset
   // ----------------------------------------------------------------

   logic [3:0] scratch [SCRATCH_WORDS];
   wire [11:0] scr_wofs = wr_idx - SCRATCH_LO;
   wire scr_wr = wr_pend & (wr_idx >= SCRATCH_LO) & (wr_idx <= SCRATCH_HI);

   // Cleared on every reset, power-down or not.
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         for (int s = 0; s < SCRATCH_WORDS; s++) begin
            scratch[s] <= 4'h0; // R04
         end
      end else begin
         for (int s = 0; s < SCRATCH_WORDS; s++) begin
            if (scr_wr && scr_wofs == 12'(s)) begin
               scratch[s] <= hwdata[3:0];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Retained storage: display memory, serial buffer, basic count
   // ----------------------------------------------------------------

   logic [3:0] disp_mem [DISP_DEPTH];
   logic [7:0] serial_shift_buffer;
   logic [7:0] basic_count_reg;
   wire [11:0] disp_wofs = wr_idx - DISP_BASE;
   wire disp_wr = wr_pend & (wr_idx >= DISP_BASE) & (disp_wofs < 12'(DISP_DEPTH));

   // No reset here: these hold their contents through a power-down reset.
   always_ff @(posedge sys_clk) begin
      for (int d = 0; d < DISP_DEPTH; d++) begin
         if (scrub) begin
            disp_mem[d] <= 4'h0; // R10
         end else if (disp_wr && disp_wofs == 12'(d)) begin
            disp_mem[d] <= hwdata[3:0];
         end
      end
      if (scrub) begin
         serial_shift_buffer <= 8'h00; // R10
      end else if (wr_pend && wr_idx == IDX_SERIAL_SHIFT_BUFFER) begin
         serial_shift_buffer <= hwdata[7:0];
      end
      if (wr_pend && wr_idx == IDX_BASIC_COUNT_REG) begin
         basic_count_reg <= hwdata[7:0]; // R06
      end
   end

   // ----------------------------------------------------------------
   // I/O ports
   // ----------------------------------------------------------------

   logic [PIN_COUNT-1:0] port_latch;
   logic [PIN_COUNT-1:0] port_direction_flag;
   logic [PIN_COUNT-1:0] pin_sync;
   logic [NUM_PORTS-1:0] latch_hit;
   logic [NUM_PORTS-1:0] dir_hit;
   logic [3:0] port_rd [NUM_PORTS];
   logic [3:0] dir_rd [NUM_PORTS];
   logic [NUM_PORTS-1:0] pullup_port;
   logic [PIN_COUNT-1:0] open_drain;
   wire [11:0] od_sel = ctrl_reg[OFS_OPEN_DRAIN_SELECT_REG][11:0];

   pin_synchronizer #(
      .WIDTH(PIN_COUNT)
   ) u_pin_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_n),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   // Open-drain selection covers ports 0, 2 and 3 only.
   assign open_drain = {24'h0, od_sel[11:8], od_sel[7:4], 4'h0, od_sel[3:0]};
   assign pullup_port = {ctrl_reg[OFS_PULLUP_SELECT_REG2][1:0], ctrl_reg[OFS_PULLUP_SELECT_REG1][7:0]};

   // Per-port decode, read-back and pull-up gating.
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      wire [3:0] dir_n = port_direction_flag[4*p +: 4];
      assign latch_hit[p] = wr_pend & (wr_idx == PORT_LATCH_BASE + 12'(p)); // R14
      assign dir_hit[p] = wr_pend & (wr_idx == DIR_BASE + 12'(DIR_SLOT[p]));
      // Output pins read back their latch, input pins their synchronized level.
      assign port_rd[p] = PIN_MASK[4*p +: 4] & ((dir_n & port_latch[4*p +: 4]) |
                                                (~dir_n & pin_sync[4*p +: 4]));
      assign dir_rd[p] = dir_n;
      assign pin_pullup[4*p +: 4] = {4{pullup_port[p]}} & ~dir_n & PIN_MASK[4*p +: 4]; // R17
   end

   // Latches and direction flags; missing pins stay zero through the masks.
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         port_latch <= '0; // R05
         port_direction_flag <= '0; // R05 R16
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (latch_hit[p]) begin
               port_latch[4*p +: 4] <= hwdata[3:0] & IO_MASK[4*p +: 4]; // R13
            end
            if (dir_hit[p]) begin
               port_direction_flag[4*p +: 4] <= hwdata[3:0] & IO_MASK[4*p +: 4]; // R13 R15
            end
         end
      end
   end

   // An open-drain pin drives only its low level; a set flag means output.
   assign pin_oe = port_direction_flag & IO_MASK & ~(open_drain & port_latch); // R15 R16 R12
   assign pin_out = port_latch;

   // Buffers stay off while the processor is held, whatever the register says.
   assign disp_out_en = ctrl_reg[OFS_DISPLAY_CONTROL_REG][DISP_ON_BIT] & ~cpu_hold; // R09

   // ----------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------

   wire [11:0] scr_rofs = idx - SCRATCH_LO;
   wire [11:0] disp_rofs = idx - DISP_BASE;
   wire scr_rd = (idx >= SCRATCH_LO) & (idx <= SCRATCH_HI);
   wire disp_rd = (idx >= DISP_BASE) & (disp_rofs < 12'(DISP_DEPTH));

   // Unmapped addresses read as zero.
   always_comb begin
      rd_data = 32'h0;
      for (int c = 0; c < NUM_CTRL; c++) begin
         if (idx == CTRL_BASE + 12'(c)) begin
            rd_data = {16'h0, ctrl_reg[c]};
         end
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (idx == PORT_LATCH_BASE + 12'(p)) begin
            rd_data = {28'h0, port_rd[p]};
         end
         if (idx == DIR_BASE + 12'(DIR_SLOT[p])) begin
            rd_data = {28'h0, dir_rd[p]};
         end
      end
      for (int s = 0; s < SCRATCH_WORDS; s++) begin
         if (scr_rd && scr_rofs == 12'(s)) begin
            rd_data = {28'h0, scratch[s]};
         end
      end
      for (int d = 0; d < DISP_DEPTH; d++) begin
         if (disp_rd && disp_rofs == 12'(d)) begin
            rd_data = {28'h0, disp_mem[d]};
         end
      end
      if (idx == IDX_SERIAL_SHIFT_BUFFER) begin
         rd_data = {24'h0, serial_shift_buffer};
      end
      if (idx == IDX_BASIC_COUNT_REG) begin
         rd_data = {24'h0, basic_count_reg};
      end
      if (idx == IDX_STATUS) begin
         rd_data[STAT_HOLD_BIT] = cpu_hold;
         rd_data[STAT_RETAINED_BIT] = retained;
      end
   end

endmodule

//--- sim/reset_init_props.sv
// Checker with port-level properties of the reset state initializer.
`timescale 1ns/10ps
module reset_init_props
   import reset_init_pkg::*;
#(
   parameter int STAB_CYCLES = 20 // Stabilization hold in clock cycles.
) (
   input wire logic sys_clk, // System clock.
   input wire logic rst_n, // External reset, active low.
   input wire logic por_n, // Power-on reset, active low.
   input wire logic hsel, // Slave select.
   input wire logic [1:0] htrans, // Transfer type.
   input wire logic hwrite, // Write.
   input wire logic hready, // Bus ready.
   input wire logic hreadyout, // Slave ready.
   input wire logic hresp, // Response.
   input wire logic [PIN_COUNT-1:0] pin_out, // Port latches.
   input wire logic [PIN_COUNT-1:0] pin_oe, // Buffer enables.
   input wire logic [PIN_COUNT-1:0] pin_pullup, // Pull-up enables.
   input wire logic disp_out_en, // Display buffers on.
   input wire logic cpu_hold, // Processor held idle.
   input wire logic mem_retained // Memories kept.
);
   // Cycles since reset release; it saturates so a long run never wraps back into the window.
   int unsigned rel_cnt;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rel_cnt <= 0;
      end else if (rel_cnt < STAB_CYCLES + 8) begin
         rel_cnt <= rel_cnt + 1;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n || !por_n);

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_resp_okay; hresp == 1'b0; endproperty
   a_resp_okay: assert property (p_resp_okay) else $error("response not okay");
   property p_rst_clear; $rose(rst_n) |-> pin_oe == '0 && pin_out == '0 && pin_pullup == '0 && cpu_hold
      && !disp_out_en && !mem_retained; endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("pins not cleared by reset");
   property p_hold_len; rel_cnt == STAB_CYCLES + 1 |-> cpu_hold ##1 !cpu_hold; endproperty
   a_hold_len: assert property (p_hold_len) else $error("hold length wrong");
   property p_disp_hold; cpu_hold |-> !disp_out_en; endproperty
   a_disp_hold: assert property (p_disp_hold) else $error("display on during hold");
   property p_pullup_off; (pin_oe & pin_pullup) == '0; endproperty
   a_pullup_off: assert property (p_pullup_off) else $error("pull-up on output pin");
   property p_pin_mask; (pin_oe & ~IO_MASK) == '0 && (pin_pullup & ~PIN_MASK) == '0; endproperty
   a_pin_mask: assert property (p_pin_mask) else $error("absent pin driven");
   property p_wr_wait; hsel && hready && htrans[1] && hwrite |=> !hreadyout ##1 hreadyout; endproperty
   a_wr_wait: assert property (p_wr_wait) else $error("write wait wrong");
   property p_rd_nowait; hsel && hready && htrans[1] && !hwrite |=> hreadyout; endproperty
   a_rd_nowait: assert property (p_rd_nowait) else $error("read waited");
   property p_out_by_write; !$stable(pin_out) |-> !$past(hreadyout); endproperty
   a_out_by_write: assert property (p_out_by_write) else $error("latch moved without write");

   // Main scenarios reached.
   c_write: cover property (hsel && hready && htrans[1] && hwrite);
   c_hold_end: cover property ($fell(cpu_hold));
   c_retained: cover property ($rose(mem_retained));
endmodule

bind reset_state_initializer reset_init_props #(.STAB_CYCLES(STAB_CYCLES)) i_props (.sys_clk, .rst_n, .por_n,
   .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .pin_out, .pin_oe, .pin_pullup, .disp_out_en,
   .cpu_hold, .mem_retained);

//--- sim/tb_reset_state_initializer.sv
// Self-checking testbench of the reset state initializer.
`timescale 1ns/10ps
module tb_reset_state_initializer
   import reset_init_pkg::*;
;
   localparam int STAB = 20;
   logic sys_clk = 0, rst_n = 0, por_n = 0, cpu_idle = 0, cpu_stop = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0] htrans = 2'b00;
   logic [39:0] pin_in = '0, pin_out, pin_oe, pin_pullup;
   logic hreadyout, hresp, disp_out_en, cpu_hold, mem_retained;
   int fails = 0, checks = 0;

   // Free-running 125 MHz clock.
   always #4 sys_clk = ~sys_clk;

   // The one slave's ready is the bus ready; only word transfers exist.
   reset_state_initializer #(.STAB_CYCLES(STAB)) i_dut (.sys_clk, .rst_n, .por_n, .cpu_idle, .cpu_stop, .hsel,
      .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .pin_in, .pin_out, .pin_oe, .pin_pullup, .disp_out_en, .cpu_hold, .mem_retained);

   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Bounded wait for ready, so a stuck slave is counted rather than hanging.
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) fails++;
   endtask

   task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {18'h0, idx, 2'b00};
      hwrite <= w;
      htrans <= 2'b10;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic wr(input logic [11:0] idx, input logic [31:0] d);
      xfer(1'b1, idx, d);
   endtask

   task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 32'h0);
      chk({8'h0, rd}, {8'h0, exp});
   endtask

   // Power-down state is set a cycle ahead so it is on record when reset falls.
   task automatic do_reset(input logic [1:0] pd);
      {cpu_stop, cpu_idle} <= pd;
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      {cpu_stop, cpu_idle} <= 2'b00;
      repeat (4) @(posedge sys_clk);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_defaults(input logic [31:0] st);
      int k;
      rdchk(IDX_STATUS, st);
      chk(40'({cpu_hold, disp_out_en}), 40'h2);
      chk(pin_oe | pin_out | pin_pullup, 40'h0);
      for (k = 0; k < NUM_CTRL; k++) begin
         rdchk(CTRL_BASE + 12'(k), 32'(CTRL_RESET[k]));
      end
      for (k = 0; k < NUM_PORTS; k++) begin
         rdchk(DIR_BASE + 12'(k), 32'h0);
         rdchk(PORT_LATCH_BASE + 12'(k), 32'h0);
      end
      $display("defaults test done");
   endtask

   task automatic t_write_all;
      int k;
      for (k = 0; k < NUM_CTRL; k++) begin
         wr(CTRL_BASE + 12'(k), 32'hffffffff);
         rdchk(CTRL_BASE + 12'(k), 32'(CTRL_MASK[k]));
      end
      repeat (STAB) @(posedge sys_clk);
      chk(40'({cpu_hold, disp_out_en}), 40'h1);
      do_reset(2'b00);
      t_defaults(32'h1);
      $display("write all test done");
   endtask

   task automatic t_ports;
      wr(DIR_BASE, 32'h5);
      wr(DIR_BASE + 12'h1, 32'hf);
      wr(DIR_BASE + 12'h9, 32'hf);
      wr(PORT_LATCH_BASE, 32'h3);
      wr(CTRL_BASE + 12'(OFS_PULLUP_SELECT_REG1), 32'h3);
      pin_in <= 40'h6c;
      repeat (3) @(posedge sys_clk);
      chk(pin_oe, 40'hf000000705);
      chk(pin_out, 40'h3);
      chk(pin_pullup, 40'hfa);
      rdchk(PORT_LATCH_BASE, 32'h9);
      rdchk(PORT_LATCH_BASE + 12'h1, 32'h6);
      rdchk(DIR_BASE + 12'h3, 32'h0);
      wr(IDX_BASIC_COUNT_REG, 32'h3c);
      rdchk(IDX_BASIC_COUNT_REG, 32'h3c);
      wr(CTRL_BASE + 12'(OFS_OPEN_DRAIN_SELECT_REG), 32'hf);
      chk(40'(pin_oe[3:0]), 40'h4);
      do_reset(2'b00);
      chk(pin_oe | pin_out | pin_pullup, 40'h0);
      pin_in <= '0;
      $display("ports test done");
   endtask

   task automatic t_retain;
      wr(DISP_BASE, 32'h9);
      wr(IDX_SERIAL_SHIFT_BUFFER, 32'h5a);
      wr(SCRATCH_LO, 32'h7);
      wr(SCRATCH_HI, 32'h6);
      do_reset(2'b10);
      chk(40'(mem_retained), 40'h1);
      rdchk(DISP_BASE, 32'h9);
      rdchk(IDX_SERIAL_SHIFT_BUFFER, 32'h5a);
      rdchk(SCRATCH_LO, 32'h0);
      rdchk(SCRATCH_HI, 32'h0);
      do_reset(2'b01);
      rdchk(DISP_BASE, 32'h9);
      do_reset(2'b00);
      chk(40'(mem_retained), 40'h0);
      rdchk(DISP_BASE, 32'h0);
      rdchk(IDX_SERIAL_SHIFT_BUFFER, 32'h0);
      $display("retain test done");
   endtask

   // ----------------------------------------------------------------
   // Verdict and sequencing
   // ----------------------------------------------------------------
   task results;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Both resets held two cycles, then the scenarios.
   initial begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_defaults(32'h1);
      t_write_all;
      t_ports;
      t_retain;
      results;
   end

   // The tests need under a thousand cycles; this cuts a hang short.
   initial begin
      #100000;
      fails++;
      results;
   end
endmodule
